// ### logic/odt_pkg.sv
// Shared constants, types and helpers of the termination control ends
package odt_pkg;

   // Clock and asynchronous path timing
   localparam int CLK_PERIOD_PS      = 10000;
   localparam int ASYNC_DELAY_MIN_PS = 2000;
   localparam int ASYNC_DELAY_MAX_PS = 8500;
   // Longest delay rounds down, but never below one cycle
   localparam int ASYNC_DELAY_CYCLES =
      (ASYNC_DELAY_MAX_PS / CLK_PERIOD_PS < 1) ? 1 :
      ASYNC_DELAY_MAX_PS / CLK_PERIOD_PS;

   // Latency figures in clock cycles
   localparam int LAT_OFFSET       = 2;
   localparam int TERM_HOLD_SHORT  = 4;
   localparam int TERM_HOLD_LONG   = 6;
   localparam int RETURN_CHOP_BASE = 4;
   localparam int RETURN_FULL_BASE = 6;

   // Nominal strength select codes
   localparam logic [2:0] NOM_OFF        = 3'h0;
   localparam logic [2:0] NOM_RZQ4       = 3'h1;
   localparam logic [2:0] NOM_RZQ2       = 3'h2;
   localparam logic [2:0] NOM_RZQ6       = 3'h3;
   localparam logic [2:0] NOM_LAST_LEGAL = 3'h5;

   // Write strength select codes
   localparam logic [1:0] WR_OFF      = 2'h0;
   localparam logic [1:0] WR_RZQ4     = 2'h1;
   localparam logic [1:0] WR_RZQ2     = 2'h2;
   localparam logic [1:0] WR_RESERVED = 2'h3;

   // Controller register map
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_MODE   = 8'h04;
   localparam logic [7:0] ADDR_CMD    = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;

   // Control register bits
   localparam int CTRL_ODT_BIT   = 0;
   localparam int CTRL_SREF_BIT  = 1;
   localparam int CTRL_READ_BIT  = 2;
   localparam int CTRL_INIT_BIT  = 3;
   localparam int CTRL_DLLD_BIT  = 4;
   localparam int CTRL_ASYNC_BIT = 5;

   // Mode register fields
   localparam int MODE_NOM_LSB = 0;
   localparam int MODE_WR_LSB  = 3;
   localparam int MODE_CWL_LSB = 5;
   localparam int MODE_AL_LSB  = 9;

   // Command register bits
   localparam int CMD_WRITE_BIT = 0;
   localparam int CMD_CHOP_BIT  = 1;

   // Status register bits
   localparam int STAT_ODT_BIT      = 0;
   localparam int STAT_HOLD_BIT     = 1;
   localparam int STAT_MODE_REJ_BIT = 2;
   localparam int STAT_CMD_REJ_BIT  = 3;
   localparam int STAT_SREF_BIT     = 4;
   localparam int STAT_READ_BIT     = 5;

   // Reset values
   localparam logic [3:0] CWL_RESET = 4'h5;
   localparam logic [3:0] AL_RESET  = 4'h0;

   typedef enum logic [1:0] {
      STRENGTH_NONE    = 2'b00,
      STRENGTH_NOMINAL = 2'b01,
      STRENGTH_WRITE   = 2'b11
   } strength_e;

   typedef enum logic [1:0] {
      MODE_OFF   = 2'b00,
      MODE_SYNC  = 2'b01,
      MODE_ASYNC = 2'b11
   } timing_mode_e;

   // Turn-on and turn-off latency, floored at one cycle
   function automatic logic [5:0] term_latency(input logic [3:0] cwl,
                                               input logic [3:0] al);
      logic [5:0] sum;
      sum = {2'h0, cwl} + {2'h0, al};
      term_latency = (sum > 6'(LAT_OFFSET)) ? sum - 6'(LAT_OFFSET) : 6'h01;
   endfunction : term_latency

endpackage : odt_pkg

// ### logic/odt_link_if.sv
// Link between the memory controller end and the termination control end
interface odt_link_if;
   logic       odt;           // Termination request pin
   logic       wr_cmd;        // Write command registered this cycle
   logic       wr_chop;       // Write is a chop-4 burst
   logic       self_refresh;  // Device in self refresh
   logic       read_busy;     // Device performing a read
   logic       dll_disabled;  // DLL disable mode
   logic       dll_async;     // DLL off in power-down or resynchronizing
   logic [2:0] nom_sel;       // Nominal termination select field
   logic [1:0] wr_sel;        // Write termination select field
   logic [3:0] cwl;           // Write latency setting
   logic [3:0] al;            // Additive latency setting

   modport ctrl (
      output odt, wr_cmd, wr_chop, self_refresh, read_busy,
      output dll_disabled, dll_async, nom_sel, wr_sel, cwl, al
   );

   modport dram (
      input odt, wr_cmd, wr_chop, self_refresh, read_busy,
      input dll_disabled, dll_async, nom_sel, wr_sel, cwl, al
   );
endinterface : odt_link_if

// ### logic/latency_pipe.sv
// Shift line with a run-time selectable tap
module latency_pipe #(
   parameter int DEPTH = 32
) (
   input  wire logic                     pclk,    // Clock
   input  wire logic                     presetn, // Async reset, low
   input  wire logic                     din,     // Sampled level
   input  wire logic [$clog2(DEPTH)-1:0] tap,     // Stage to read
   output logic                          dout     // Delayed level
);
   typedef struct packed {
      logic [DEPTH-1:0] sr;
   } pipe_s;

   pipe_s state_reg;
   pipe_s state_next;

   always_comb begin
      state_next    = state_reg;
      state_next.sr = {state_reg.sr[DEPTH-2:0], din};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign dout = state_reg.sr[tap];
endmodule : latency_pipe

// ### logic/odt_term_ctrl.sv
// Termination control end: on/off timing and strength selection
// What this block and the controller end do
// - No termination while DLL is disabled
// - Ignore pin in self refresh or disabled
// - Controller lowers pin before self refresh
// - Nominal codes: 000 off, 001-101 on, 110-111 illegal
// - Nominal follows registered pin level
// - Controller keeps pin low during reads
// - Nominal during writes only RZQ/2,4,6 while write code is 00
// - Request only initialized, not reading, not refreshing
// - Sync turn-on after CWL+AL-2 cycles
// - Sync turn-off after CWL+AL-2 cycles
// - Async switching within 2 to 8.5 ns; here after one 10 ns clock cycle
// - Controller holds pin high 4 or 6
// - Async timing when DLL off or resyncing
// - Write strength per burst, no mode command
// - Write strength only during write bursts
// - Covers data, strobe, mask, termination strobe balls
// - Write switching when select code is 01 or 10
// - Switch to write strength after WL-2
// - Return after 4 or 6 plus off latency
// - Write codes: 00 off, 01 RZQ/4, 10 RZQ/2, 11 reserved
module odt_term_ctrl #(
   parameter int DQ_WIDTH   = 8,  // Data balls
   parameter int DQS_WIDTH  = 1,  // Strobe pairs
   parameter int DM_WIDTH   = 1,  // Mask balls
   parameter int TERMINATION_STROBE_PAIRS = 1,  // Termination strobe pairs
   parameter int PIPE_DEPTH = 32  // Longest latency handled
) (
   odt_link_if.dram                 link,          // Controller side
   input  wire logic                pclk,          // Clock
   input  wire logic                presetn,       // Async reset, low
   input  wire logic                termination_strobe_enable,   // Termination strobe on
   output logic                     term_on,       // Termination active
   output odt_pkg::strength_e       term_strength, // Which value applies
   output logic [2:0]               term_code,     // Select code in use
   output odt_pkg::timing_mode_e    timing_mode,   // Current timing mode
   output logic [DQ_WIDTH+2*DQS_WIDTH+DM_WIDTH+2*TERMINATION_STROBE_PAIRS-1:0]
                                    ball_term_en   // Per-ball switch
);
   localparam int BALLS      = DQ_WIDTH + 2 * DQS_WIDTH + DM_WIDTH;
   localparam int TAP_W      = $clog2(PIPE_DEPTH);

   typedef struct packed {
      logic                  term_on;
      odt_pkg::strength_e    strength;
      logic [2:0]            code;
      odt_pkg::timing_mode_e mode;
      logic                  wr_active;
      logic [5:0]            wr_cnt;
      logic [5:0]            wr_ret;
   } term_s;

   term_s state_reg;
   term_s state_next;

   logic       nom_en;
   logic       wr_en;
   logic       pin_gated;
   logic       pin_delayed;
   logic [5:0] lat;
   logic [5:0] wl;
   logic [TAP_W-1:0] tap;

   assign nom_en = (link.nom_sel != odt_pkg::NOM_OFF) &&
                   (link.nom_sel <= odt_pkg::NOM_LAST_LEGAL);
   assign wr_en  = (link.wr_sel == odt_pkg::WR_RZQ4) ||
                   (link.wr_sel == odt_pkg::WR_RZQ2);
   // Pin ignored in self refresh or when both selects are off
   assign pin_gated = link.odt && !link.self_refresh &&
                      (nom_en || wr_en);
   assign lat = odt_pkg::term_latency(link.cwl, link.al);
   assign wl  = {2'h0, link.cwl} + {2'h0, link.al};
   // Stage lat-1 plus the output flop gives lat cycles from sampling
   assign tap = TAP_W'(lat - 6'h01);

   latency_pipe #(
      .DEPTH (PIPE_DEPTH)
   ) u_on_pipe (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (pin_gated),
      .tap     (tap),
      .dout    (pin_delayed)
   );

   always_comb begin
      logic       on_next;
      logic       in_window;
      logic [5:0] sw_lat;
      on_next   = 1'b0;
      in_window = 1'b0;
      sw_lat    = (wl > 6'(odt_pkg::LAT_OFFSET)) ?
                  wl - 6'(odt_pkg::LAT_OFFSET) : 6'h00;
      state_next = state_reg;

      // Timing mode selection
      if (link.dll_disabled) begin
         state_next.mode = odt_pkg::MODE_OFF;
      end else if (link.dll_async) begin
         state_next.mode = odt_pkg::MODE_ASYNC;
      end else begin
         state_next.mode = odt_pkg::MODE_SYNC;
      end

      // Write window tracking; a new write restarts the window
      if (link.wr_cmd && wr_en &&
          state_next.mode == odt_pkg::MODE_SYNC) begin
         state_next.wr_active = 1'b1;
         state_next.wr_cnt    = 6'h00;
         state_next.wr_ret    = link.wr_chop ?
            lat + 6'(odt_pkg::RETURN_CHOP_BASE) :
            lat + 6'(odt_pkg::RETURN_FULL_BASE);
      end else if (state_reg.wr_active) begin
         state_next.wr_cnt = state_reg.wr_cnt + 6'h01;
         if (state_next.wr_cnt >= state_reg.wr_ret) begin
            state_next.wr_active = 1'b0;
         end
      end
      if (state_next.mode != odt_pkg::MODE_SYNC || !wr_en) begin
         state_next.wr_active = 1'b0;
      end
      in_window = state_next.wr_active &&
                  state_next.wr_cnt >= sw_lat;

      // On/off level: delayed in sync mode, direct in async mode
      case (state_next.mode)
         odt_pkg::MODE_SYNC: begin
            on_next = pin_delayed;
         end
         odt_pkg::MODE_ASYNC: begin
            // One cycle of 10 ns (CLK_PERIOD_PS) is longer than the allowed 2 to 8.5 ns window
            on_next = pin_gated;
         end
         default: begin
            on_next = 1'b0;
         end
      endcase

      // Strength: write value replaces none or nominal in the window
      if (on_next && in_window) begin
         state_next.term_on  = 1'b1;
         state_next.strength = odt_pkg::STRENGTH_WRITE;
         state_next.code     = {1'b0, link.wr_sel};
      end else if (on_next && nom_en) begin
         state_next.term_on  = 1'b1;
         state_next.strength = odt_pkg::STRENGTH_NOMINAL;
         state_next.code     = link.nom_sel;
      end else begin
         state_next.term_on  = 1'b0;
         state_next.strength = odt_pkg::STRENGTH_NONE;
         state_next.code     = 3'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= '{term_on:   1'b0,
                        strength:  odt_pkg::STRENGTH_NONE,
                        code:      3'h0,
                        mode:      odt_pkg::MODE_OFF,
                        wr_active: 1'b0,
                        wr_cnt:    6'h00,
                        wr_ret:    6'h00};
      end else begin
         state_reg <= state_next;
      end
   end

   assign term_on       = state_reg.term_on;
   assign term_strength = state_reg.strength;
   assign term_code     = state_reg.code;
   assign timing_mode   = state_reg.mode;
   // Termination strobe pair only follows when enabled
   assign ball_term_en = {{(2 * TERMINATION_STROBE_PAIRS){state_reg.term_on && termination_strobe_enable}},
                          {BALLS{state_reg.term_on}}};
endmodule : odt_term_ctrl

// ### logic/odt_mem_ctrl.sv
// Controller end: APB registers drive the termination pin and commands
//
// Our own choices: register access over APB and the placing of the registers.
module odt_mem_ctrl (
   odt_link_if.ctrl    link,    // Device side
   input  wire logic        pclk,    // Clock
   input  wire logic        presetn, // Async reset, low
   input  wire logic        psel,    // APB select
   input  wire logic        penable, // APB access phase
   input  wire logic        pwrite,  // APB write
   input  wire logic [7:0]  paddr,   // APB byte address
   input  wire logic [31:0] pwdata,  // APB write data
   output logic [31:0]      prdata,  // APB read data
   output logic             pready,  // APB ready
   output logic             pslverr  // APB error
);
   typedef struct packed {
      logic [5:0]  ctrl;
      logic [2:0]  nom_sel;
      logic [1:0]  wr_sel;
      logic [3:0]  cwl;
      logic [3:0]  al;
      logic        odt;
      logic        sref;
      logic        read;
      logic        wr_cmd;
      logic        wr_chop;
      logic [2:0]  hold;
      logic        mode_rej;
      logic        cmd_rej;
      logic [31:0] rdata;
   } host_s;

   host_s state_reg;
   host_s state_next;

   logic wr_acc;
   logic rd_acc;
   logic mapped;

   assign mapped = (paddr == odt_pkg::ADDR_CTRL) ||
                   (paddr == odt_pkg::ADDR_MODE) ||
                   (paddr == odt_pkg::ADDR_CMD)  ||
                   (paddr == odt_pkg::ADDR_STATUS);
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && !penable && !pwrite;

   always_comb begin
      logic [2:0] n_nom;
      logic [1:0] n_wr;
      logic       want;
      logic       legal;
      n_nom = pwdata[odt_pkg::MODE_NOM_LSB +: 3];
      n_wr  = pwdata[odt_pkg::MODE_WR_LSB +: 2];
      // Reserved codes refused; nominal used in writes limited
      legal = (n_nom <= odt_pkg::NOM_LAST_LEGAL) &&
              (n_wr != odt_pkg::WR_RESERVED) &&
              (n_wr != odt_pkg::WR_OFF || n_nom == odt_pkg::NOM_OFF ||
               n_nom == odt_pkg::NOM_RZQ2 || n_nom == odt_pkg::NOM_RZQ4 ||
               n_nom == odt_pkg::NOM_RZQ6);
      state_next        = state_reg;
      state_next.wr_cmd = 1'b0;
      if (state_reg.hold != 3'h0) begin
         state_next.hold = state_reg.hold - 3'h1;
      end

      if (wr_acc) begin
         case (paddr)
            odt_pkg::ADDR_CTRL: begin
               state_next.ctrl = pwdata[5:0];
            end
            odt_pkg::ADDR_MODE: begin
               if (legal) begin
                  state_next.nom_sel = n_nom;
                  state_next.wr_sel  = n_wr;
                  state_next.cwl = pwdata[odt_pkg::MODE_CWL_LSB +: 4];
                  state_next.al  = pwdata[odt_pkg::MODE_AL_LSB +: 4];
               end else begin
                  state_next.mode_rej = 1'b1;
               end
            end
            odt_pkg::ADDR_CMD: begin
               // Writes refused while reading or in self refresh
               if (pwdata[odt_pkg::CMD_WRITE_BIT] && !state_reg.read &&
                   !state_reg.sref) begin
                  state_next.wr_cmd  = 1'b1;
                  state_next.wr_chop = pwdata[odt_pkg::CMD_CHOP_BIT];
                  if (state_reg.odt) begin
                     state_next.hold = pwdata[odt_pkg::CMD_CHOP_BIT] ?
                        3'(odt_pkg::TERM_HOLD_SHORT - 1) :
                        3'(odt_pkg::TERM_HOLD_LONG - 1);
                  end
               end else if (pwdata[odt_pkg::CMD_WRITE_BIT]) begin
                  state_next.cmd_rej = 1'b1;
               end
            end
            odt_pkg::ADDR_STATUS: begin
               // Write one to clear; a same-cycle set is kept below
               if (pwdata[odt_pkg::STAT_MODE_REJ_BIT] &&
                   state_next.mode_rej == state_reg.mode_rej) begin
                  state_next.mode_rej = 1'b0;
               end
               if (pwdata[odt_pkg::STAT_CMD_REJ_BIT] &&
                   state_next.cmd_rej == state_reg.cmd_rej) begin
                  state_next.cmd_rej = 1'b0;
               end
            end
            default: begin
               state_next.rdata = state_reg.rdata;
            end
         endcase
      end

      // Pin request gated by init, read and self refresh demands
      want = state_reg.ctrl[odt_pkg::CTRL_ODT_BIT] &&
             state_reg.ctrl[odt_pkg::CTRL_INIT_BIT] &&
             !state_reg.ctrl[odt_pkg::CTRL_READ_BIT] &&
             !state_reg.ctrl[odt_pkg::CTRL_SREF_BIT];
      if (want && !state_reg.read && !state_reg.sref) begin
         if (!state_reg.odt) begin
            state_next.hold = 3'(odt_pkg::TERM_HOLD_SHORT - 1);
         end
         state_next.odt = 1'b1;
      end else if (state_reg.hold == 3'h0 && !state_next.wr_cmd) begin
         state_next.odt = 1'b0;
      end
      // Read and self refresh start only once the pin is low
      state_next.read = state_reg.ctrl[odt_pkg::CTRL_READ_BIT] &&
                        (state_reg.read || !state_reg.odt);
      state_next.sref = state_reg.ctrl[odt_pkg::CTRL_SREF_BIT] &&
                        (state_reg.sref || !state_reg.odt);

      if (rd_acc) begin
         case (paddr)
            odt_pkg::ADDR_CTRL: begin
               state_next.rdata = {26'h0, state_reg.ctrl};
            end
            odt_pkg::ADDR_MODE: begin
               state_next.rdata = {19'h0, state_reg.al, state_reg.cwl,
                                   state_reg.wr_sel, state_reg.nom_sel};
            end
            odt_pkg::ADDR_STATUS: begin
               state_next.rdata = {26'h0, state_reg.read, state_reg.sref,
                                   state_reg.cmd_rej, state_reg.mode_rej,
                                   state_reg.hold != 3'h0, state_reg.odt};
            end
            default: begin
               state_next.rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= '{ctrl: 6'h00, nom_sel: odt_pkg::NOM_OFF,
                        wr_sel: odt_pkg::WR_OFF,
                        cwl: odt_pkg::CWL_RESET, al: odt_pkg::AL_RESET,
                        odt: 1'b0, sref: 1'b0, read: 1'b0,
                        wr_cmd: 1'b0, wr_chop: 1'b0, hold: 3'h0,
                        mode_rej: 1'b0, cmd_rej: 1'b0,
                        rdata: 32'h0000_0000};
      end else begin
         state_reg <= state_next;
      end
   end

   assign prdata            = state_reg.rdata;
   assign pready            = 1'b1;
   assign pslverr           = psel && penable && !mapped;
   assign link.odt          = state_reg.odt;
   assign link.wr_cmd       = state_reg.wr_cmd;
   assign link.wr_chop      = state_reg.wr_chop;
   assign link.self_refresh = state_reg.sref;
   assign link.read_busy    = state_reg.read;
   assign link.dll_disabled = state_reg.ctrl[odt_pkg::CTRL_DLLD_BIT];
   assign link.dll_async    = state_reg.ctrl[odt_pkg::CTRL_ASYNC_BIT];
   assign link.nom_sel      = state_reg.nom_sel;
   assign link.wr_sel       = state_reg.wr_sel;
   assign link.cwl          = state_reg.cwl;
   assign link.al           = state_reg.al;
endmodule : odt_mem_ctrl

// ### bench/odt_link_sva.sv
// Checker on the link between controller end and termination end
module odt_link_sva (
   input wire logic                  pclk,          // Clock
   input wire logic                  presetn,       // Async reset, low
   input wire logic                  odt,           // Request pin
   input wire logic                  wr_cmd,        // Write pulse
   input wire logic                  wr_chop,       // Chop-4 write
   input wire logic                  self_refresh,  // Self refresh
   input wire logic                  read_busy,     // Read active
   input wire logic                  dll_disabled,  // DLL off mode
   input wire logic                  dll_async,     // Async timing
   input wire logic [2:0]            nom_sel,       // Nominal code
   input wire logic [1:0]            wr_sel,        // Write code
   input wire logic [3:0]            cwl,           // Write latency
   input wire logic [3:0]            al,            // Additive latency
   input wire logic                  term_on,       // Termination on
   input wire odt_pkg::strength_e    term_strength, // Strength
   input wire odt_pkg::timing_mode_e timing_mode    // Timing mode
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Sync and write checks only at cwl 5, al 0, so the latency is a plain 3
   logic sync_ok;
   logic wr_on;
   assign sync_ok = cwl == 4'h5 && al == 4'h0 && nom_sel == 3'h1 &&
      !self_refresh && !dll_async && !dll_disabled &&
      timing_mode == odt_pkg::MODE_SYNC;
   assign wr_on = wr_sel == 2'h1 || wr_sel == 2'h2;

   read_odt_low_a: assert property (read_busy |-> !odt)
      else $error("pin high during read");
   sref_odt_low_a: assert property ($rose(self_refresh) |-> !odt)
      else $error("pin high at self refresh entry");
   hold_short_a: assert property ($rose(odt) |-> odt[*4])
      else $error("pin high under four cycles");
   dll_off_a: assert property (dll_disabled[*3] |-> !term_on)
      else $error("termination on with DLL disabled");
   // Output flop adds one edge: pin sampled at T-4 shows at T
   sync_on_a: assert property (sync_ok[*5] ##0 $past(odt, 4)
      |-> term_on)
      else $error("late or missing turn-on");
   sync_off_a: assert property (sync_ok[*5] ##0 !$past(odt, 4)
      |-> !term_on)
      else $error("late or missing turn-off");
   wr_switch_a: assert property (wr_cmd && sync_ok && wr_on
      ##1 (sync_ok && wr_on)[*4]
      |-> !term_on || term_strength == odt_pkg::STRENGTH_WRITE)
      else $error("no write strength after write latency");
   async_follow_a: assert property ((dll_async && !dll_disabled &&
      nom_sel == 3'h1 && !self_refresh)[*3] |-> term_on == $past(odt))
      else $error("async termination not following pin");

   cover property (wr_cmd && wr_chop);
   cover property (term_strength == odt_pkg::STRENGTH_WRITE);
   cover property (timing_mode == odt_pkg::MODE_ASYNC && term_on);
endmodule : odt_link_sva

// ### bench/tb.sv
// Bench joining both termination ends over APB
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  pclk = 1'b0;
   logic                  presetn = 1'b0;
   logic                  psel = 1'b0;
   logic                  penable = 1'b0;
   logic                  pwrite = 1'b0;
   logic [7:0]            paddr = 8'h00;
   logic [31:0]           pwdata = 32'h0;
   logic [31:0]           prdata;
   logic                  pready;
   logic                  pslverr;
   logic                  termination_strobe_enable = 1'b1;
   logic                  term_on;
   odt_pkg::strength_e    term_strength;
   logic [2:0]            term_code;
   odt_pkg::timing_mode_e timing_mode;
   logic [12:0]           ball_term_en;
   logic [31:0]           rd;
   int                    errors = 0;
   int                    comparisons = 0;

   always #5 pclk = ~pclk;
   odt_link_if link();
   odt_mem_ctrl i_odt_mem_ctrl (.link(link), .pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   odt_term_ctrl i_odt_term_ctrl (.link(link), .pclk, .presetn,
      .termination_strobe_enable, .term_on, .term_strength, .term_code, .timing_mode,
      .ball_term_en);
   odt_link_sva i_odt_link_sva (.pclk, .presetn, .odt(link.odt),
      .wr_cmd(link.wr_cmd), .wr_chop(link.wr_chop),
      .self_refresh(link.self_refresh), .read_busy(link.read_busy),
      .dll_disabled(link.dll_disabled), .dll_async(link.dll_async),
      .nom_sel(link.nom_sel), .wr_sel(link.wr_sel), .cwl(link.cwl),
      .al(link.al), .term_on, .term_strength, .timing_mode);

   task automatic conclude();
      $display("checks %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // Ends one idle cycle after release so the next setup never collides
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         check("pready", 32'h1, 32'h0);
         conclude();
      end
      rd = pslverr ? 32'hFFFFFFFF : prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // Bounded wait on term_on (sel 0) or term_strength (sel 1)
   task automatic await_out(input bit sel, input logic [31:0] v);
      int n;
      n = 0;
      while ((sel ? 32'(term_strength) : 32'(term_on)) !== v) begin
         @(posedge pclk);
         if (++n > 40) begin
            check(sel ? "strength" : "term_on", v, 32'hX);
            conclude();
         end
      end
   endtask : await_out

   task automatic s_regs();
      apb(1'b0, odt_pkg::ADDR_MODE, 32'h0);
      check("mode reset", 32'h000000A0, rd);
      apb(1'b0, 8'h10, 32'h0);
      check("unmapped", 32'hFFFFFFFF, rd);
   endtask : s_regs

   task automatic s_nominal();
      apb(1'b1, odt_pkg::ADDR_MODE, 32'h000000A1);
      apb(1'b1, odt_pkg::ADDR_CTRL, 32'h9);
      await_out(1'b1, 32'(odt_pkg::STRENGTH_NOMINAL));
      check("balls", 32'h1FFF, 32'(ball_term_en));
      // Strobe pair disabled: only data, strobe and mask balls follow
      termination_strobe_enable <= 1'b0;
      @(posedge pclk);
      check("balls no pair", 32'h07FF, 32'(ball_term_en));
      termination_strobe_enable <= 1'b1;
      apb(1'b1, odt_pkg::ADDR_CTRL, 32'h8);
      await_out(1'b0, 32'h0);
   endtask : s_nominal

   task automatic s_illegal();
      logic [31:0] bad [4] = '{32'hA6, 32'hA7, 32'hB9, 32'hA4};
      foreach (bad[i]) begin
         apb(1'b1, odt_pkg::ADDR_MODE, bad[i]);
         apb(1'b0, odt_pkg::ADDR_MODE, 32'h0);
         check("mode kept", 32'h000000A1, rd);
      end
      apb(1'b0, odt_pkg::ADDR_STATUS, 32'h0);
      check("mode reject", 32'h4, rd & 32'h4);
   endtask : s_illegal

   task automatic s_write();
      int n;
      for (int w = 1; w < 3; w++) begin
         apb(1'b1, odt_pkg::ADDR_MODE, 32'hA1 | (w << 3));
         apb(1'b1, odt_pkg::ADDR_CTRL, 32'h9);
         await_out(1'b0, 32'h1);
         // First pass a chop-4 write, second pass an 8-beat write
         apb(1'b1, odt_pkg::ADDR_CMD, (w == 1) ? 32'h3 : 32'h1);
         await_out(1'b1, 32'(odt_pkg::STRENGTH_WRITE));
         check("wr code", 32'(w), 32'(term_code));
         n = 0;
         while (term_strength == odt_pkg::STRENGTH_WRITE && n < 40) begin
            @(posedge pclk);
            n++;
         end
         check("wr cycles", (w == 1) ? 32'(odt_pkg::RETURN_CHOP_BASE) :
               32'(odt_pkg::RETURN_FULL_BASE), n);
         await_out(1'b1, 32'(odt_pkg::STRENGTH_NOMINAL));
         apb(1'b1, odt_pkg::ADDR_CTRL, 32'h8);
         await_out(1'b0, 32'h0);
      end
   endtask : s_write

   task automatic s_sref_read();
      apb(1'b1, odt_pkg::ADDR_MODE, 32'h000000A1);
      apb(1'b1, odt_pkg::ADDR_CTRL, 32'h9);
      await_out(1'b0, 32'h1);
      apb(1'b1, odt_pkg::ADDR_CTRL, 32'hB);
      await_out(1'b0, 32'h0);
      apb(1'b0, odt_pkg::ADDR_STATUS, 32'h0);
      check("sref status", 32'h10, rd & 32'h11);
      apb(1'b1, odt_pkg::ADDR_CTRL, 32'hD);
      repeat (3) @(posedge pclk);
      apb(1'b1, odt_pkg::ADDR_CMD, 32'h1);
      apb(1'b0, odt_pkg::ADDR_STATUS, 32'h0);
      check("read status", 32'h28, rd & 32'h39);
   endtask : s_sref_read

   task automatic s_dll();
      apb(1'b1, odt_pkg::ADDR_CTRL, 32'h19);
      repeat (10) @(posedge pclk);
      check("dll off", 32'h0, 32'(term_on));
      apb(1'b1, odt_pkg::ADDR_CTRL, 32'h29);
      await_out(1'b0, 32'h1);
      check("mode", 32'(odt_pkg::MODE_ASYNC), 32'(timing_mode));
      apb(1'b1, odt_pkg::ADDR_CTRL, 32'h28);
      await_out(1'b0, 32'h0);
   endtask : s_dll

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      s_regs();
      s_nominal();
      s_illegal();
      s_write();
      s_sref_read();
      s_dll();
      conclude();
   end
endmodule : tb
